// *** inc/atten_ctrl_pkg.sv ***
// attenuator controller package: codes, timing constants, carrier structs
// assumes a 20 MHz system clock; no registers, all control is by ports
package atten_ctrl_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   // minimum setup of select pins before a strobe rise, and strobe high width
   localparam int unsigned SETUP_NS = 100;
   localparam int unsigned STROBE_NS = 100;
   // settling after a change before reporting done
   localparam int unsigned SETTLE_NS = 130;
   localparam int unsigned SETUP_CYC = (SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int unsigned STROBE_CYC = (STROBE_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int unsigned SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int unsigned CNT_W = 8;
   // attenuation codes: bit 0 is the 16 dB weight, bit 1 the 32 dB weight
   localparam logic [1:0] ATT_0DB = 2'h0;
   localparam logic [1:0] ATT_16DB = 2'h1;
   localparam logic [1:0] ATT_32DB = 2'h2;
   localparam logic [1:0] ATT_48DB = 2'h3;
   localparam logic [1:0] RESET_CODE = ATT_48DB;

   typedef enum logic {MODE_LATCHED, MODE_DIRECT} mode_t;

   // pins toward the attenuator
   typedef struct packed {
      logic load_strobe;
      logic select_bit_high_weight;
      logic select_bit_low_weight;
   } atten_pins_t;

   // request from the user side
   typedef struct packed {
      logic valid;
      logic [1:0] code;
   } atten_req_t;
endpackage : atten_ctrl_pkg

// *** design/step_timer.sv ***
// step_timer: loadable down counter that pulses done the cycle after it reaches zero
// assumes one clock domain; load and count come from the owning fsm
`timescale 1ns/1ps
module step_timer #(
   parameter int unsigned W = 8
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic load_i,
   input wire logic [W-1:0] count_i,
   output logic done_o
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic run_q;
   wire last_w = run_q && (cnt_q == '0);

   // refuse a counter too narrow to hold a reload value
   if (W < 2) begin : g_bad_width
      $error("step_timer width too small");
   end

   // reload or count down
   assign cnt_d = load_i ? count_i : (run_q && !last_w) ? cnt_q - 1'b1 : cnt_q;

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         done_o <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         run_q <= load_i ? 1'b1 : (last_w ? 1'b0 : run_q);
         done_o <= last_w && !load_i;
      end
   end
endmodule : step_timer

// *** design/atten_ctrl.sv ***
// atten_ctrl: controller that drives the select pins and load strobe of a 2-bit step
// attenuator in direct or latched mode, and sequences its power-up and power-down
// assumes supply-good and rf request inputs are asynchronous; one 20 MHz clock
`timescale 1ns/1ps
// Contract
// - in direct mode the strobe stays high from the end of the power-up load until power-down, and the select pins follow the requested code.
// - in latched mode the strobe is low whenever the select pins change.
// - once the select pins are stable the strobe is raised to transfer them.
// - after the transfer the strobe returns low so the device holds the state.
// - the pins are driven only once both supplies are up, and rf is enabled only after that.
// - at power-down rf is removed first, then the pins are released, then supplies may drop.
module atten_ctrl
   import atten_ctrl_pkg::*;
#(
   parameter int unsigned SETUP_C = SETUP_CYC,
   parameter int unsigned STROBE_C = STROBE_CYC,
   parameter int unsigned SETTLE_C = SETTLE_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic supply_pos_good_i,
   input wire logic supply_neg_good_i,
   input wire logic power_down_req_i,
   input wire logic rf_req_i,
   input wire logic mode_direct_i,
   input wire logic req_valid_i,
   input wire logic [1:0] req_code_i,
   output logic load_strobe_o,
   output logic select_bit_low_weight_o,
   output logic select_bit_high_weight_o,
   output logic pins_drive_en_b_o,
   output logic rf_enable_o,
   output logic supplies_release_o,
   output logic ready_o,
   output logic busy_o,
   output logic [1:0] applied_code_o
);
   // refuse timing counts that the step timer cannot serve
   if (SETUP_C < 1 || STROBE_C < 1 || SETTLE_C < 1) begin : g_bad_min
      $error("timing counts must be at least one");
   end
   if (SETUP_C >= (1 << CNT_W) || STROBE_C >= (1 << CNT_W) || SETTLE_C >= (1 << CNT_W))
   begin : g_bad_max
      $error("timing counts exceed timer width");
   end

   typedef enum logic [2:0] {
      ST_OFF, ST_SETUP, ST_STROBE, ST_SETTLE, ST_IDLE, ST_RF_OFF, ST_RELEASE
   } state_t;

   // two-flop synchronisers for asynchronous inputs; supplies combine only after them
   logic [3:0] async_w;
   logic [3:0] meta_q;
   logic [3:0] sync_q;
   assign async_w = {supply_pos_good_i, supply_neg_good_i, power_down_req_i, rf_req_i};
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_q <= 4'h0;
         sync_q <= 4'h0;
      end else begin
         meta_q <= async_w;
         sync_q <= meta_q;
      end
   end
   wire supplies_up_w = sync_q[3] & sync_q[2];
   wire pd_req_w = sync_q[1];
   wire rf_want_w = sync_q[0];

   state_t state_q;
   state_t state_d;
   atten_pins_t pins_q;
   atten_pins_t pins_d;
   atten_req_t pend_q;
   atten_req_t pend_d;
   mode_t mode_q;
   logic loaded_q;
   logic rf_q;
   logic drive_q;
   logic [1:0] applied_q;
   logic [1:0] applied_d;
   logic tmr_load;
   logic [CNT_W-1:0] tmr_cnt;
   logic tmr_done;

   step_timer #(.W(CNT_W)) u_timer (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .load_i(tmr_load),
      .count_i(tmr_cnt),
      .done_o(tmr_done)
   );

   // request decode
   wire new_req_w = req_valid_i && (state_q == ST_IDLE) && !pd_req_w;
   wire go_down_w = pd_req_w || !supplies_up_w;

   // next state and pin values
   always_comb begin
      state_d = state_q;
      pins_d = pins_q;
      pend_d = pend_q;
      applied_d = applied_q;
      tmr_load = 1'b0;
      tmr_cnt = '0;
      case (state_q)
         ST_OFF: begin
            if (supplies_up_w && !pd_req_w) begin
               // first load of the reset code, strobe low while pins settle
               pins_d = '{load_strobe: 1'b0,
                  select_bit_high_weight: RESET_CODE[1],
                  select_bit_low_weight: RESET_CODE[0]};
               pend_d = '{valid: 1'b1, code: RESET_CODE};
               tmr_load = 1'b1;
               tmr_cnt = CNT_W'(SETUP_C);
               state_d = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (tmr_done) begin
               pins_d.load_strobe = 1'b1;
               tmr_load = 1'b1;
               tmr_cnt = CNT_W'(STROBE_C);
               state_d = ST_STROBE;
            end
         end
         ST_STROBE: begin
            if (tmr_done) begin
               pins_d.load_strobe = (mode_q == MODE_DIRECT);
               applied_d = pend_q.code;
               pend_d.valid = 1'b0;
               tmr_load = 1'b1;
               tmr_cnt = CNT_W'(SETTLE_C);
               state_d = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (tmr_done) state_d = ST_IDLE;
         end
         ST_IDLE: begin
            if (go_down_w) begin
               state_d = ST_RF_OFF;
            end else if (new_req_w && mode_q == MODE_DIRECT) begin
               // strobe held high: pins go straight through
               pins_d.select_bit_low_weight = req_code_i[0];
               pins_d.select_bit_high_weight = req_code_i[1];
               pins_d.load_strobe = 1'b1;
               applied_d = req_code_i;
               tmr_load = 1'b1;
               tmr_cnt = CNT_W'(SETTLE_C);
               state_d = ST_SETTLE;
            end else if (new_req_w) begin
               pins_d.load_strobe = 1'b0;
               pins_d.select_bit_low_weight = req_code_i[0];
               pins_d.select_bit_high_weight = req_code_i[1];
               pend_d = '{valid: 1'b1, code: req_code_i};
               tmr_load = 1'b1;
               tmr_cnt = CNT_W'(SETUP_C);
               state_d = ST_SETUP;
            end
         end
         ST_RF_OFF: begin
            // rf is dropped this cycle; wait settle before releasing pins
            tmr_load = 1'b1;
            tmr_cnt = CNT_W'(SETTLE_C);
            state_d = ST_RELEASE;
         end
         ST_RELEASE: begin
            if (tmr_done) begin
               pins_d = '0;
               state_d = ST_OFF;
            end
         end
         default: state_d = ST_OFF;
      endcase
   end

   // rf is allowed only with pins driven, a load done and no shutdown
   wire rf_d = rf_want_w && loaded_q && drive_q && (state_q == ST_IDLE || state_q == ST_SETTLE
      || state_q == ST_SETUP || state_q == ST_STROBE) && !go_down_w;
   wire drive_d = (state_d != ST_OFF);
   wire loaded_d = (state_q == ST_OFF) ? 1'b0 : (loaded_q || (state_q == ST_STROBE && tmr_done));
   // next state, not current: release must drop on the edge the pins start driving
   wire rel_d = (state_d == ST_OFF) && !drive_q && !rf_q;
   // mode changes only between transfers
   wire mode_take_w = (state_q == ST_IDLE || state_q == ST_OFF);

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= ST_OFF;
         pins_q <= '0;
         pend_q <= '0;
         mode_q <= MODE_LATCHED;
         loaded_q <= 1'b0;
         rf_q <= 1'b0;
         drive_q <= 1'b0;
         applied_q <= ATT_0DB;
      end else begin
         state_q <= state_d;
         pins_q <= pins_d;
         pend_q <= pend_d;
         if (mode_take_w && !new_req_w) mode_q <= mode_t'(mode_direct_i);
         loaded_q <= loaded_d;
         rf_q <= rf_d;
         drive_q <= drive_d;
         applied_q <= applied_d;
      end
   end

   // outputs straight from flops
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         load_strobe_o <= 1'b0;
         select_bit_low_weight_o <= 1'b0;
         select_bit_high_weight_o <= 1'b0;
         pins_drive_en_b_o <= 1'b1;
         rf_enable_o <= 1'b0;
         supplies_release_o <= 1'b1;
         ready_o <= 1'b0;
         busy_o <= 1'b0;
         applied_code_o <= ATT_0DB;
      end else begin
         load_strobe_o <= pins_d.load_strobe;
         select_bit_low_weight_o <= pins_d.select_bit_low_weight;
         select_bit_high_weight_o <= pins_d.select_bit_high_weight;
         pins_drive_en_b_o <= !drive_d;
         rf_enable_o <= rf_d;
         supplies_release_o <= rel_d;
         ready_o <= (state_d == ST_IDLE) && loaded_d;
         busy_o <= (state_d != ST_IDLE) && (state_d != ST_OFF);
         applied_code_o <= applied_d;
      end
   end
endmodule : atten_ctrl

// *** dv/atten_ctrl_sva.sv ***
// atten_ctrl_sva: concurrent checks on the controller's attenuator pins and status
// assumes default timing parameters; attached to atten_ctrl by the bind below
`timescale 1ns/1ps
module atten_ctrl_sva #(
   parameter int unsigned SETUP_C = 2,
   parameter int unsigned STROBE_C = 2,
   parameter int unsigned SETTLE_C = 3
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic supply_pos_good_i,
   input wire logic supply_neg_good_i,
   input wire logic power_down_req_i,
   input wire logic mode_direct_i,
   input wire logic load_strobe_o,
   input wire logic select_bit_low_weight_o,
   input wire logic select_bit_high_weight_o,
   input wire logic pins_drive_en_b_o,
   input wire logic rf_enable_o,
   input wire logic supplies_release_o,
   input wire logic ready_o,
   input wire logic [1:0] applied_code_o
);
   // select pins as one code
   wire [1:0] pins_w = {select_bit_high_weight_o, select_bit_low_weight_o};
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   // strobe and select timing
   a_latched_pins_quiet: assert property (
      !mode_direct_i && $changed(pins_w) |-> !load_strobe_o)
      else $error("select pins moved with strobe high");
   a_setup_before_rise: assert property (
      $rose(load_strobe_o) |-> pins_w == $past(pins_w, 2))
      else $error("select pins not settled before strobe");
   // strobe stands for the strobe count plus the step timer's two cycles of latency
   a_strobe_pulse_width: assert property (
      $rose(load_strobe_o) && !mode_direct_i |=> load_strobe_o [*3] ##1 !load_strobe_o)
      else $error("strobe pulse width wrong");
   // a fall while the pins are released is not a capture
   a_capture_on_fall: assert property (
      $fell(load_strobe_o) && !pins_drive_en_b_o |-> applied_code_o == pins_w)
      else $error("applied code differs from latched pins");
   a_direct_follow: assert property (
      ready_o && mode_direct_i |-> load_strobe_o && applied_code_o == pins_w)
      else $error("direct mode strobe or code wrong");
   // power sequencing
   a_rf_needs_pins: assert property (
      rf_enable_o |-> !pins_drive_en_b_o && !supplies_release_o)
      else $error("rf enabled without driven pins");
   a_drive_after_supply: assert property (
      $fell(pins_drive_en_b_o) |-> $past(supply_pos_good_i, 3) && $past(supply_neg_good_i, 3))
      else $error("pins driven before supplies good");
   a_rf_drop_first: assert property (
      $rose(power_down_req_i) |-> ##[0:4] !rf_enable_o)
      else $error("rf not removed at power-down");
   a_release_last: assert property (
      $rose(supplies_release_o) |-> $past(pins_drive_en_b_o) && !rf_enable_o)
      else $error("supplies released before pins");
   a_release_pins_off: assert property (
      supplies_release_o |-> pins_drive_en_b_o && !rf_enable_o)
      else $error("supplies released while pins or rf active");
   a_ready_after_load: assert property (
      $rose(ready_o) |-> applied_code_o == pins_w && !pins_drive_en_b_o)
      else $error("ready without a completed load");
   // main scenarios
   c_strobe: cover property ($rose(load_strobe_o));
   c_rf_on: cover property ($rose(rf_enable_o));
   c_release: cover property ($rose(supplies_release_o));
   c_direct_ready: cover property (mode_direct_i && $rose(ready_o));
endmodule : atten_ctrl_sva
bind atten_ctrl atten_ctrl_sva #(
   .SETUP_C(SETUP_C),
   .STROBE_C(STROBE_C),
   .SETTLE_C(SETTLE_C)
) atten_ctrl_sva_inst (.*);

// *** dv/atten_device_model.sv ***
// atten_device_model: behavioural 2-bit step attenuator with latch strobe
// assumes pins count only while driven; state is unknown until the first load
`timescale 1ns/1ps
module atten_device_model (
   input wire logic load_strobe_o,
   input wire logic select_bit_low_weight_o,
   input wire logic select_bit_high_weight_o,
   input wire logic pins_drive_en_b_o,
   output logic [1:0] dev_state_o
);
   // a released strobe pin reads low
   wire strobe_w = load_strobe_o && !pins_drive_en_b_o;
   // transparent while strobe high, holds while low
   always_latch begin
      if (strobe_w) begin
         dev_state_o = {select_bit_high_weight_o, select_bit_low_weight_o};
      end
   end
endmodule : atten_device_model

// *** dv/tb_top.sv ***
// tb_top: self-checking bench for atten_ctrl with an attenuator model
// assumes the default timing parameters and a 20 MHz clock
`timescale 1ns/1ps
module tb_top;
   import atten_ctrl_pkg::*;
   logic sys_clk_i, rst_b_i, supply_pos_good_i, supply_neg_good_i, power_down_req_i;
   logic rf_req_i, mode_direct_i, req_valid_i, load_strobe_o, select_bit_low_weight_o;
   logic select_bit_high_weight_o, pins_drive_en_b_o, rf_enable_o, supplies_release_o;
   logic ready_o, busy_o;
   logic [1:0] req_code_i, applied_code_o, dev_state_o;
   int failures = 0;
   int total_checks = 0;
   atten_ctrl atten_ctrl_inst (.*);
   atten_device_model atten_device_model_inst (.*);
   // clock
   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   // compare and count
   task chk(input logic [1:0] seen, input logic [1:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task final_report();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report
   // bounded wait: 0 ready, 1 rf enable, 2 supplies release
   task wt(input int which);
      int n;
      n = 0;
      while ((which == 0 ? ready_o : which == 1 ? rf_enable_o : supplies_release_o) !== 1'b1) begin
         @(negedge sys_clk_i);
         n++;
         if (n > 200) begin
            failures++;
            final_report();
         end
      end
   endtask : wt
   task pwr_up();
      supply_pos_good_i = 1'b1;
      supply_neg_good_i = 1'b1;
      wt(0);
      chk(applied_code_o, ATT_48DB);
      chk(dev_state_o, ATT_48DB);
      chk({pins_drive_en_b_o, rf_enable_o}, 2'h0);
   endtask : pwr_up
   task rf_on();
      rf_req_i = 1'b1;
      wt(1);
      chk({pins_drive_en_b_o, supplies_release_o}, 2'h0);
   endtask : rf_on
   // one load; a second code offered while busy must be ignored
   task ld(input logic [1:0] c);
      req_valid_i = 1'b1;
      req_code_i = c;
      @(negedge sys_clk_i);
      req_code_i = ~c;
      repeat (2) @(negedge sys_clk_i);
      req_valid_i = 1'b0;
      chk({ready_o, busy_o}, 2'h1);
      wt(0);
      chk(applied_code_o, c);
      chk(dev_state_o, c);
      chk({1'b0, load_strobe_o}, {1'b0, mode_direct_i});
   endtask : ld
   task pwr_dn();
      power_down_req_i = 1'b1;
      wt(2);
      chk({pins_drive_en_b_o, rf_enable_o}, 2'h2);
      supply_pos_good_i = 1'b0;
      supply_neg_good_i = 1'b0;
      power_down_req_i = 1'b0;
      rf_req_i = 1'b0;
      repeat (6) @(negedge sys_clk_i);
   endtask : pwr_dn
   // main sequence: latched pass, then direct pass
   initial begin
      {rst_b_i, supply_pos_good_i, supply_neg_good_i, power_down_req_i} = 4'h0;
      {rf_req_i, mode_direct_i, req_valid_i, req_code_i} = 5'h00;
      repeat (6) @(negedge sys_clk_i);
      rst_b_i = 1'b1;
      pwr_up();
      rf_on();
      for (int i = 0; i < 4; i++) ld(2'(i));
      ld(ATT_0DB);
      pwr_dn();
      mode_direct_i = 1'b1;
      pwr_up();
      for (int i = 3; i >= 0; i--) ld(2'(i));
      rf_on();
      pwr_dn();
      final_report();
   end
endmodule : tb_top
